// File: uls_defs.svh
`ifndef ULS_DEFS_SVH
`define ULS_DEFS_SVH

// Register byte addresses on the Wishbone slave (word aligned).
`define ULS_ADDR_LSR 4'h0
`define ULS_ADDR_CTRL 4'h4
`define ULS_ADDR_ISTAT 4'h8
`define ULS_ADDR_IMASK 4'hC

// Line status bit positions.
`define ULS_LSR_DR 0
`define ULS_LSR_OE 1
`define ULS_LSR_PE 2
`define ULS_LSR_FE 3
`define ULS_LSR_BI 4
`define ULS_LSR_THRE 5
`define ULS_LSR_TEMT 6
`define ULS_LSR_FERR 7

// Control register bit positions and reset value.
`define ULS_CTRL_FIFO_EN 0
`define ULS_CTRL_THRE_IE 1
`define ULS_CTRL_RST 2'h0

// Interrupt status and mask bit positions, width and reset value.
`define ULS_IS_RX 0
`define ULS_IS_LERR 1
`define ULS_IS_THRE 2
`define ULS_IS_W 3
`define ULS_IS_RST 3'h0

// Structural defaults.
`define ULS_FIFO_DEPTH 16
`define ULS_FIFO_AW 4
`define ULS_CHAR_CAP 5'h01
`define ULS_LSR_RST 8'h60
`define ULS_DAT_ZERO 32'h0000_0000

`endif

// File: uls_pkg.sv
package uls_pkg;

	// Error tags that travel with each received character.
	typedef struct packed {
		logic bi;
		logic fe;
		logic pe;
	} uls_tag_t;

	// Break detector states, one-hot.
	typedef enum logic [2:0] {
		BRK_IDLE = 3'h1,
		BRK_COUNT = 3'h2,
		BRK_HELD = 3'h4
	} uls_brk_state_t;

	// True when a character carries any error that counts toward the summary bit.
	function automatic logic uls_any_err(input uls_tag_t tag);
		uls_any_err = tag.pe | tag.fe | tag.bi;
	endfunction : uls_any_err

endpackage : uls_pkg

// File: uls_err_track.sv
`timescale 1ns/1ps
`include "uls_defs.svh"

// Mirrors the receive FIFO occupancy and keeps the error tag of every stored character.
module uls_err_track import uls_pkg::*; #(
	parameter int DEPTH = `ULS_FIFO_DEPTH,
	parameter int AW = `ULS_FIFO_AW
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input uls_tag_t tag_i,
	input wire logic pop_i,
	input wire logic [AW:0] cap_i,
	output uls_tag_t head_o,
	output logic [AW:0] count_o,
	output logic [AW:0] err_cnt_o,
	output logic full_o,
	output logic empty_o
);

	uls_tag_t tags_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] cnt_ff;
	logic [AW:0] err_ff;

	// A full tracker refuses the push, so stored tags are never disturbed.
	assign empty_o = cnt_ff == '0;
	assign full_o = cnt_ff >= cap_i;
	assign head_o = tags_ff[rd_ptr_ff];
	assign count_o = cnt_ff;
	assign err_cnt_o = err_ff;

	wire push_ok = push_i & ~full_o;
	wire pop_ok = pop_i & ~empty_o;
	wire err_in = push_ok & uls_any_err(tag_i);
	wire err_out = pop_ok & uls_any_err(head_o);

	// Pointers, occupancy and the count of errored characters.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			err_ff <= '0;
		end else begin
			if (push_ok) begin
				tags_ff[wr_ptr_ff] <= tag_i;
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop_ok) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + {{AW{1'b0}}, push_ok} - {{AW{1'b0}}, pop_ok};
			err_ff <= err_ff + {{AW{1'b0}}, err_in} - {{AW{1'b0}}, err_out};
		end
	end

endmodule : uls_err_track

// File: uls_line_status.sv
`timescale 1ns/1ps
`include "uls_defs.svh"

// Summary of operation
// - FIFO mode: error summary bit 7 sets when a character with parity, framing or break enters the FIFO.
// - Reading the line status register clears the error summary bit.
// - Character mode: bit 6 high only when holding and shift registers are both empty.
// - FIFO mode: bit 6 sets only when transmit FIFO and shift register are empty.
// - Character mode: bit 5 sets when the holding register moves into the shift register.
// - Character mode: bit 5 clears with the host write into the holding register.
// - FIFO mode: bit 5 follows transmit FIFO empty, clears after one byte written.
// - Interrupt request raised while bit 5 and its interrupt enable are both set.
// - Break bit 4 sets after the receive line stays low one whole frame.
// - Only one break character is pushed per break condition, however long.
// - Framing bit 3 sets when a character lacks a valid stop bit.
// - FIFO mode: framing bit reflects the character at the FIFO head.
// - Summary, break and framing bits read zero when no condition exists.
// - Parity bit 2 sets on bad parity; FIFO mode reflects the head character.
// - Overrun bit 1 sets when a character completes with the FIFO full; FIFO untouched.
// - Data-ready bit 0 is high while any received character is held.
module uls_line_status import uls_pkg::*; #(
	parameter int DEPTH = `ULS_FIFO_DEPTH,
	parameter int AW = `ULS_FIFO_AW
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic thr_wr_i,
	input wire logic tsr_load_i,
	input wire logic tx_shift_busy_i,
	input wire logic tx_fifo_empty_i,
	input wire logic rxd_i,
	input wire logic bit_tick_i,
	input wire logic [3:0] frame_bits_i,
	input wire logic rx_done_i,
	input uls_tag_t rx_flags_i,
	input wire logic rx_pop_i,
	output logic fifo_en_o,
	output logic [7:0] line_status_o,
	output logic irq_o
);

	logic wb_ack_ff;
	logic [31:0] wb_dat_ff;
	logic [1:0] ctrl_ff;
	logic [`ULS_IS_W-1:0] istat_ff;
	logic [`ULS_IS_W-1:0] imask_ff;
	logic [`ULS_IS_W-1:0] nxt_istat;
	logic [7:0] line_status_ff;
	logic [7:0] nxt_line_status;
	logic thr_full_ff;
	logic thre_d_ff;
	logic oe_ff;
	logic pe_ff;
	logic fe_ff;
	logic bi_ff;
	logic ferr_ff;
	logic irq_ff;
	logic [3:0] brk_cnt_ff;
	uls_brk_state_t brk_st_ff;
	uls_brk_state_t nxt_brk_st;
	logic [31:0] rd_data;

	uls_tag_t head;
	uls_tag_t push_tag;
	logic [AW:0] trk_cnt;
	logic [AW:0] err_cnt;
	logic trk_full;
	logic trk_empty;

	// Bus decode; the side effects happen once, on the first cycle of each request.
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
	wire hit_lsr = wb_adr_i == `ULS_ADDR_LSR;
	wire hit_ctrl = wb_adr_i == `ULS_ADDR_CTRL;
	wire hit_istat = wb_adr_i == `ULS_ADDR_ISTAT;
	wire hit_imask = wb_adr_i == `ULS_ADDR_IMASK;
	wire wr_lane0 = wb_req & wb_we_i & wb_sel_i[0];
	wire lsr_rd = wb_req & ~wb_we_i & hit_lsr;
	wire fifo_en = ctrl_ff[`ULS_CTRL_FIFO_EN];
	wire thre_ie = ctrl_ff[`ULS_CTRL_THRE_IE];
	wire [`ULS_IS_W-1:0] w1c = (wr_lane0 & hit_istat) ? wb_dat_i[`ULS_IS_W-1:0] : '0;

	// Transmit side: holding register occupancy and the two empty indicators.
	wire thre = fifo_en ? tx_fifo_empty_i : ~thr_full_ff;
	wire temt = thre & ~tx_shift_busy_i;

	// Break detector: counts bit times while the line is low, fires once per low period.
	wire brk_last = brk_cnt_ff == frame_bits_i - 4'h1;
	wire brk_evt = (brk_st_ff == BRK_COUNT) & ~rxd_i & bit_tick_i & brk_last;

	// Receive side: a break occupies one FIFO entry tagged as break.
	wire push = rx_done_i | brk_evt;
	// One assignment for the whole tag keeps a single driver on the struct variable.
	assign push_tag = '{bi: brk_evt, fe: rx_done_i & rx_flags_i.fe, pe: rx_done_i & rx_flags_i.pe};
	wire push_ok = push & ~trk_full;
	wire overrun = push & trk_full;
	wire err_push = push_ok & uls_any_err(push_tag);
	wire [AW:0] cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(`ULS_CHAR_CAP);

	uls_err_track #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_track (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(push),
		.tag_i(push_tag),
		.pop_i(rx_pop_i),
		.cap_i(cap),
		.head_o(head),
		.count_o(trk_cnt),
		.err_cnt_o(err_cnt),
		.full_o(trk_full),
		.empty_o(trk_empty)
	);

	// Next break detector state; a high line always rearms it.
	always_comb begin
		nxt_brk_st = brk_st_ff;
		case (brk_st_ff)
			BRK_IDLE: begin
				if (~rxd_i) begin
					nxt_brk_st = BRK_COUNT;
				end
			end
			BRK_COUNT: begin
				if (rxd_i) begin
					nxt_brk_st = BRK_IDLE;
				end else if (brk_evt) begin
					nxt_brk_st = BRK_HELD;
				end
			end
			BRK_HELD: begin
				if (rxd_i) begin
					nxt_brk_st = BRK_IDLE;
				end
			end
			default: begin
				nxt_brk_st = BRK_IDLE;
			end
		endcase
	end

	// Assembled status byte; FIFO mode shows the head tags, character mode the sticky bits.
	always_comb begin
		nxt_line_status = '0;
		nxt_line_status[`ULS_LSR_DR] = ~trk_empty;
		nxt_line_status[`ULS_LSR_OE] = oe_ff;
		nxt_line_status[`ULS_LSR_PE] = fifo_en ? (head.pe & ~trk_empty) : pe_ff;
		nxt_line_status[`ULS_LSR_FE] = fifo_en ? (head.fe & ~trk_empty) : fe_ff;
		nxt_line_status[`ULS_LSR_BI] = fifo_en ? (head.bi & ~trk_empty) : bi_ff;
		nxt_line_status[`ULS_LSR_THRE] = thre;
		nxt_line_status[`ULS_LSR_TEMT] = temt;
		nxt_line_status[`ULS_LSR_FERR] = ferr_ff;
	end

	// Interrupt events win over a same-cycle write-one-to-clear.
	always_comb begin
		nxt_istat = istat_ff & ~w1c;
		nxt_istat[`ULS_IS_RX] = nxt_istat[`ULS_IS_RX] | push_ok;
		nxt_istat[`ULS_IS_LERR] = nxt_istat[`ULS_IS_LERR] | overrun | err_push;
		nxt_istat[`ULS_IS_THRE] = nxt_istat[`ULS_IS_THRE] | (thre & ~thre_d_ff);
	end

	// Read mux; unmapped addresses read zero and are still acknowledged.
	always_comb begin
		rd_data = `ULS_DAT_ZERO;
		if (hit_lsr) begin
			rd_data[7:0] = line_status_ff;
		end else if (hit_ctrl) begin
			rd_data[1:0] = ctrl_ff;
		end else if (hit_istat) begin
			rd_data[`ULS_IS_W-1:0] = istat_ff;
		end else if (hit_imask) begin
			rd_data[`ULS_IS_W-1:0] = imask_ff;
		end
	end

	// Wishbone slave: one wait state, ack drops the cycle after it is given.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_ff <= 1'b0;
			wb_dat_ff <= `ULS_DAT_ZERO;
		end else begin
			wb_ack_ff <= wb_req;
			wb_dat_ff <= (wb_req & ~wb_we_i) ? rd_data : `ULS_DAT_ZERO;
		end
	end

	// Software-written control, status and mask registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= `ULS_CTRL_RST;
			imask_ff <= `ULS_IS_RST;
			istat_ff <= `ULS_IS_RST;
		end else begin
			if (wr_lane0 & hit_ctrl) begin
				ctrl_ff <= wb_dat_i[1:0];
			end
			if (wr_lane0 & hit_imask) begin
				imask_ff <= wb_dat_i[`ULS_IS_W-1:0];
			end
			istat_ff <= nxt_istat;
		end
	end

	// Transmit holding register: a host write wins over a same-cycle move to the shifter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thr_full_ff <= 1'b0;
			thre_d_ff <= 1'b1;
		end else begin
			thr_full_ff <= thr_wr_i | (thr_full_ff & ~tsr_load_i);
			thre_d_ff <= thre;
		end
	end

	// Sticky receive errors; a new event in the read cycle survives the clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_ff <= 1'b0;
			pe_ff <= 1'b0;
			fe_ff <= 1'b0;
			bi_ff <= 1'b0;
			ferr_ff <= 1'b0;
		end else begin
			oe_ff <= overrun | (oe_ff & ~lsr_rd);
			pe_ff <= (push_ok & push_tag.pe) | (pe_ff & ~lsr_rd);
			fe_ff <= (push_ok & push_tag.fe) | (fe_ff & ~lsr_rd);
			bi_ff <= (push_ok & push_tag.bi) | (bi_ff & ~lsr_rd);
			ferr_ff <= fifo_en & (err_push | (ferr_ff & ~lsr_rd & (err_cnt != '0)));
		end
	end

	// Break counter and state, then registered outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brk_st_ff <= BRK_IDLE;
			brk_cnt_ff <= '0;
			line_status_ff <= `ULS_LSR_RST;
			irq_ff <= 1'b0;
		end else begin
			brk_st_ff <= nxt_brk_st;
			brk_cnt_ff <= (rxd_i | brk_st_ff != BRK_COUNT) ? '0 : brk_cnt_ff + {3'h0, bit_tick_i};
			line_status_ff <= nxt_line_status;
			irq_ff <= (thre & thre_ie) | (|(istat_ff & imask_ff));
		end
	end

	assign wb_ack_o = wb_ack_ff;
	assign wb_dat_o = wb_dat_ff;
	assign fifo_en_o = ctrl_ff[`ULS_CTRL_FIFO_EN];
	assign line_status_o = line_status_ff;
	assign irq_o = irq_ff;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_err_sum_set: assert property (fifo_en && err_push |=> ferr_ff ##1 line_status_ff[`ULS_LSR_FERR])
		else $error("error summary not set by errored character");
	chk_err_sum_clr: assert property (lsr_rd && !err_push |=> !ferr_ff)
		else $error("error summary not cleared by status read");
	chk_temt_char: assert property ($past(!fifo_en && (thr_full_ff || tx_shift_busy_i))
		|-> !line_status_ff[`ULS_LSR_TEMT])
		else $error("transmitter empty shown while character mode holds data");
	chk_temt_fifo: assert property ($past(fifo_en && !tx_fifo_empty_i) |-> !line_status_ff[`ULS_LSR_TEMT])
		else $error("transmitter empty shown while transmit FIFO holds data");
	chk_thre_load: assert property ((!fifo_en && tsr_load_i && !thr_wr_i) ##1 (!fifo_en && !thr_wr_i)
		|=> line_status_ff[`ULS_LSR_THRE])
		else $error("holding empty not set after move to shifter");
	chk_thre_write: assert property ((!fifo_en && thr_wr_i) ##1 !fifo_en |=> !line_status_ff[`ULS_LSR_THRE])
		else $error("holding empty not cleared by host write");
	chk_thre_fifo: assert property (fifo_en && !tx_fifo_empty_i |=> !line_status_ff[`ULS_LSR_THRE])
		else $error("holding empty shown with bytes in transmit FIFO");
	chk_thre_irq: assert property (thre && thre_ie |=> irq_o)
		else $error("holding empty interrupt missing");
	chk_brk_single: assert property (brk_evt |=> !brk_evt [*8])
		else $error("second break character in one break");
	chk_ovr_keep: assert property (overrun && !rx_pop_i |=> oe_ff && $stable(trk_cnt))
		else $error("overrun not flagged or FIFO disturbed");
	chk_dr_level: assert property (!trk_empty |=> line_status_ff[`ULS_LSR_DR])
		else $error("data ready low with characters held");

	cov_break: cover property (brk_evt ##1 brk_st_ff == BRK_HELD);
	cov_overrun: cover property (fifo_en && overrun);
	cov_lsr_read_err: cover property (lsr_rd && ferr_ff);

endmodule : uls_line_status

// File: uls_host_model.sv
`timescale 1ns/1ps

// Host processor on the register bus: issues one classic Wishbone cycle at a time.
module uls_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [3:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);

	// The bus is quiet at time zero so the slave never sees an unknown request.
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 4'h0;
		sel_o = 4'hF;
		dat_o = 32'h0000_0000;
	end

	// Holds the request until ack is sampled high; the bound keeps a dead slave from hanging the run.
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clk_i);
			ok = (ack_i === 1'b1);
		end
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask : xfer

endmodule : uls_host_model

// File: tb_uls_line_status.sv
`timescale 1ns/1ps
`include "uls_defs.svh"

module tb_uls_line_status import uls_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc, wb_stb, wb_we, wb_ack, fifo_en, irq, ok;
	logic [3:0] wb_adr, wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r;
	logic [4:0] strb = 5'h00; // Bit tick, pop, receive done, shift load, holding write.
	logic shift_busy = 1'b0;
	logic txf_empty = 1'b1;
	logic rxd = 1'b1;
	logic [3:0] frame_bits = 4'h4;
	uls_tag_t rx_flags = '0;
	logic [7:0] line_status;
	logic [31:0] exp_q[$];
	int errors = 0;
	int n_compared = 0;
	int nb = 0;

	// A 4 ns clock.
	always #2 clk_i = ~clk_i;

	uls_line_status uls_line_status_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
		.wb_ack_o(wb_ack), .thr_wr_i(strb[0]), .tsr_load_i(strb[1]), .tx_shift_busy_i(shift_busy),
		.tx_fifo_empty_i(txf_empty), .rxd_i(rxd), .bit_tick_i(strb[4]), .frame_bits_i(frame_bits),
		.rx_done_i(strb[2]), .rx_flags_i(rx_flags), .rx_pop_i(strb[3]), .fifo_en_o(fifo_en),
		.line_status_o(line_status), .irq_o(irq));

	uls_host_model uls_host_model_inst (.clk_i(clk_i), .ack_i(wb_ack), .cyc_o(wb_cyc), .stb_o(wb_stb),
		.we_o(wb_we), .adr_o(wb_adr), .sel_o(wb_sel), .dat_o(wb_dat_w));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	// One-cycle strobe, then a settle time that covers the two-edge status lag.
	task pulse(input int i);
		@(posedge clk_i);
		strb[i] <= 1'b1;
		@(posedge clk_i);
		strb[i] <= 1'b0;
		idle(3);
	endtask : pulse

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		uls_host_model_inst.xfer(w, a, d, ok);
		if (ok) begin
			idle(2);
		end else begin
			errors++;
			report_and_stop();
		end
	endtask : bus

	// The expected word is noted before the cycle starts; the monitor matches it at ack.
	task rd(input logic [3:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Read data is taken only at the edge where ack is high, as a real master would.
	always @(posedge clk_i) begin
		if (wb_ack === 1'b1 && wb_we === 1'b0) begin
			if (exp_q.size() == 0)
				check(wb_dat_r, 32'hDEAD_0000);
			else
				check(wb_dat_r, exp_q.pop_front());
		end
	end

	// Main sequence: character mode first, then FIFO mode, so the mode bit is crossed once.
	initial begin
		void'($urandom(40));
		idle(6);
		rst_i <= 1'b0;
		idle(1);
		rd(`ULS_ADDR_LSR, 32'h60);
		pulse(0);
		check({24'h0, line_status}, 32'h00);
		rd(`ULS_ADDR_LSR, 32'h00);
		shift_busy <= 1'b1;
		pulse(1);
		rd(`ULS_ADDR_LSR, 32'h20);
		shift_busy <= 1'b0;
		idle(3);
		rd(`ULS_ADDR_LSR, 32'h60);
		bus(1'b1, `ULS_ADDR_CTRL, 32'h2);
		check(irq, 1'b1);
		pulse(0);
		check(irq, 1'b0);
		pulse(1);
		bus(1'b1, `ULS_ADDR_CTRL, 32'h0);
		$display("character transmit done");
		rx_flags <= '{bi: 1'b0, fe: 1'b0, pe: 1'b1};
		pulse(2);
		rd(`ULS_ADDR_LSR, 32'h65);
		rd(`ULS_ADDR_LSR, 32'h61);
		rx_flags <= '0;
		pulse(2);
		rd(`ULS_ADDR_LSR, 32'h63);
		rd(`ULS_ADDR_LSR, 32'h61);
		pulse(3);
		rd(`ULS_ADDR_LSR, 32'h60);
		// Old events are cleared first, so the interrupt below can only come from the new character.
		bus(1'b1, `ULS_ADDR_ISTAT, 32'h7);
		bus(1'b1, `ULS_ADDR_IMASK, 32'h1);
		check(irq, 1'b0);
		pulse(2);
		check(irq, 1'b1);
		bus(1'b1, `ULS_ADDR_ISTAT, 32'h7);
		check(irq, 1'b0);
		bus(1'b1, `ULS_ADDR_IMASK, 32'h0);
		pulse(3);
		$display("character receive done");
		bus(1'b1, `ULS_ADDR_CTRL, 32'h1);
		rd(`ULS_ADDR_CTRL, 32'h1);
		check(fifo_en, 1'b1);
		rx_flags <= '{bi: 1'b0, fe: 1'b1, pe: 1'b0};
		pulse(2);
		rx_flags <= '0;
		pulse(2);
		rd(`ULS_ADDR_LSR, 32'hE9);
		rd(`ULS_ADDR_LSR, 32'h69);
		pulse(3);
		rd(`ULS_ADDR_LSR, 32'h61);
		pulse(3);
		rd(`ULS_ADDR_LSR, 32'h60);
		// A random frame length, then at least that many low bit times and a random overhang.
		nb = 2 + $urandom % 6;
		frame_bits <= 4'(nb);
		rxd <= 1'b0;
		repeat (nb + $urandom % 8) pulse(4);
		rd(`ULS_ADDR_LSR, 32'hF1);
		pulse(3);
		rd(`ULS_ADDR_LSR, 32'h60);
		rxd <= 1'b1;
		repeat (17) pulse(2);
		check({24'h0, line_status}, 32'h63);
		rd(`ULS_ADDR_LSR, 32'h63);
		rd(`ULS_ADDR_LSR, 32'h61);
		repeat (15) pulse(3);
		rd(`ULS_ADDR_LSR, 32'h61);
		pulse(3);
		rd(`ULS_ADDR_LSR, 32'h60);
		$display("fifo receive done");
		txf_empty <= 1'b0;
		idle(3);
		rd(`ULS_ADDR_LSR, 32'h00);
		txf_empty <= 1'b1;
		shift_busy <= 1'b1;
		idle(3);
		check({24'h0, line_status}, 32'h20);
		rd(`ULS_ADDR_LSR, 32'h20);
		shift_busy <= 1'b0;
		idle(3);
		rd(`ULS_ADDR_LSR, 32'h60);
		check({24'h0, line_status}, 32'h60);
		$display("fifo transmit done");
		report_and_stop();
	end
endmodule : tb_uls_line_status
